// File: logic/sar_port_defs.svh
// Constants of the serial conversion port: frame positions and timing.
// Assumes the includer works in shift-clock edges and a 20 MHz ref_clk.
`ifndef SAR_PORT_DEFS_SVH
`define SAR_PORT_DEFS_SVH

// ----------------------------------------------------------------------
// Frame positions, in shift-clock rising edges after the strobe fall
// ----------------------------------------------------------------------
`define LAST_ZERO_EDGE 5'h03
`define MSB_EDGE 5'h04
`define TRACK_EDGE 5'h0E
`define SUB_LOW_EDGE 5'h0F
`define FRAME_EDGES 5'h10
`define PD_FIRST_EDGE 5'h04
`define PD_LAST_EDGE 5'h0E
`define FIRST_TRIAL 12'h800

// ----------------------------------------------------------------------
// Power-down sequencing
// ----------------------------------------------------------------------
`define PD_MIN_LOW 4'h3
`define PD_MAX_LOW 4'hD
`define WAKE_LOW_EDGES 4'hE
`define PARTIAL_WAKE_CYCLES 5'h10

// ----------------------------------------------------------------------
// Full power-down recovery time
// ----------------------------------------------------------------------
`define FULL_WAKE_TIME_US 2000
`define REF_CLK_HZ 20000000

`endif

// File: logic/sar_port_pkg.sv
// Types shared by the serial conversion port.
// Assumes sar_port_defs.svh supplies the numeric constants.
package sar_port_pkg;

   // ----------------------------------------------------------------------
   // Link-side control
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_POWER_DOWN
   } link_state_e;

   typedef enum logic [1:0] {
      PD_NONE,
      PD_PARTIAL,
      PD_FULL
   } pd_level_e;

   // ----------------------------------------------------------------------
   // Status carried from the link domain to ref_clk
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic partial_down;
      logic full_down;
      logic recovering;
      logic cal_pending;
   } link_status_s;

endpackage

// File: logic/sync_level.sv
// Two-flop level synchroniser, WIDTH independent bits.
// Assumes each input bit is a level held long compared with the clock.
`timescale 1ns/1ps
`default_nettype none

module sync_level #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end

endmodule // sync_level

`default_nettype wire

// File: logic/sar_conversion_port.sv
// Conversion control and serial readout of a 12-bit SAR converter.
// Assumes the master drives strobe and shift clock from one source, so
// the strobe and the comparator decision are sampled on shift_clk as is.
`timescale 1ns/1ps
`default_nettype none
`include "sar_port_defs.svh"

module sar_conversion_port #(
   parameter bit BIPOLAR = 1'b0,
   parameter int FULL_WAKE_CYCLES =
      `FULL_WAKE_TIME_US * (`REF_CLK_HZ / 1000000)
) (
   // System clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Serial link
   input wire logic shift_clk,
   input wire logic convert_start_strobe,
   output logic data_out,
   output logic data_out_oe,
   // Analog front end
   input wire logic cmp_above,
   output logic [11:0] dac_trial,
   output logic track_mode,
   // Status in the ref_clk domain
   output sar_port_pkg::link_status_s status,
   output logic wake_busy
);

   localparam int WAKE_W = $clog2(FULL_WAKE_CYCLES + 1);
   localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(FULL_WAKE_CYCLES);

   // ----------------------------------------------------------------------
   // Link domain state
   // ----------------------------------------------------------------------
   sar_port_pkg::link_state_e state, next_state;
   sar_port_pkg::pd_level_e pd_level, next_pd_level;
   sar_port_pkg::link_status_s link_stat, next_link_stat;
   logic strobe_q, next_strobe_q;
   logic [4:0] edge_cnt, next_edge_cnt;
   logic [3:0] low_cnt, next_low_cnt;
   logic [4:0] recover, next_recover;
   logic cal, next_cal;
   logic wake_tgl, next_wake_tgl;
   logic next_data_out, next_data_out_oe, next_track_mode;
   logic [11:0] next_dac_trial;
   logic [4:0] e;
   logic [3:0] bit_idx;
   logic strobe_fall, strobe_rise;

   always_comb begin
      next_state = state;
      next_pd_level = pd_level;
      next_strobe_q = convert_start_strobe;
      next_edge_cnt = edge_cnt;
      next_low_cnt = low_cnt;
      next_recover = recover;
      next_cal = cal;
      next_wake_tgl = wake_tgl;
      next_data_out = data_out;
      next_data_out_oe = data_out_oe;
      next_track_mode = track_mode;
      next_dac_trial = dac_trial;
      e = 5'(edge_cnt + 5'h01);
      bit_idx = 4'(`SUB_LOW_EDGE - e);
      strobe_fall = strobe_q & ~convert_start_strobe;
      strobe_rise = ~strobe_q & convert_start_strobe;
      if (recover != 5'h00) begin
         next_recover = 5'(recover - 5'h01);
      end
      case (state)
         sar_port_pkg::ST_IDLE: begin
            if (strobe_fall) begin
               // Output stays on from a continuous frame, else turns on
               next_state = sar_port_pkg::ST_CONVERT;
               next_edge_cnt = 5'h01;
               next_track_mode = 1'b0;
               next_data_out_oe = 1'b1;
               next_data_out = 1'b0;
               next_dac_trial = 12'h000;
            end
         end
         sar_port_pkg::ST_CONVERT: begin
            next_edge_cnt = e;
            if (convert_start_strobe && e >= `PD_FIRST_EDGE &&
                e <= `PD_LAST_EDGE) begin
               next_state = sar_port_pkg::ST_POWER_DOWN;
               next_pd_level = sar_port_pkg::PD_PARTIAL;
               next_data_out_oe = 1'b0;
               next_data_out = 1'b0;
               next_track_mode = 1'b1;
               next_low_cnt = 4'h0;
            end else if (convert_start_strobe && e < `MSB_EDGE) begin
               // Strobe pulled back too early: frame dropped
               next_state = sar_port_pkg::ST_IDLE;
               next_data_out_oe = 1'b0;
               next_data_out = 1'b0;
               next_track_mode = 1'b1;
            end else if (e <= `LAST_ZERO_EDGE) begin
               next_data_out = 1'b0;
               if (e == `LAST_ZERO_EDGE) begin
                  next_dac_trial = `FIRST_TRIAL;
               end
            end else if (e <= `SUB_LOW_EDGE) begin
               // Decision goes straight to the pin, no pipeline stage
               next_dac_trial[bit_idx] = cmp_above;
               if (bit_idx != 4'h0) begin
                  next_dac_trial[bit_idx - 4'h1] = 1'b1;
               end
               next_data_out = cmp_above ^
                  (BIPOLAR && e == `MSB_EDGE);
               if (e == `TRACK_EDGE) begin
                  next_track_mode = 1'b1;
               end
            end else if (e == `FRAME_EDGES) begin
               next_data_out = 1'b0;
               next_cal = 1'b0;
               if (convert_start_strobe) begin
                  next_state = sar_port_pkg::ST_IDLE;
               end
            end else begin
               next_state = sar_port_pkg::ST_IDLE;
               next_data_out_oe = 1'b0;
            end
         end
         sar_port_pkg::ST_POWER_DOWN: begin
            next_track_mode = 1'b1;
            if (!convert_start_strobe && low_cnt != 4'hF) begin
               next_low_cnt = 4'(low_cnt + 4'h1);
            end
            if (strobe_rise) begin
               next_low_cnt = 4'h0;
               if (low_cnt >= `WAKE_LOW_EDGES) begin
                  next_state = sar_port_pkg::ST_IDLE;
                  next_pd_level = sar_port_pkg::PD_NONE;
                  if (pd_level == sar_port_pkg::PD_PARTIAL) begin
                     next_recover = `PARTIAL_WAKE_CYCLES;
                  end else begin
                     next_wake_tgl = ~wake_tgl;
                  end
               end else if (low_cnt >= `PD_MIN_LOW &&
                            low_cnt <= `PD_MAX_LOW &&
                            pd_level == sar_port_pkg::PD_PARTIAL) begin
                  next_pd_level = sar_port_pkg::PD_FULL;
               end
            end
         end
         default: begin
            next_state = sar_port_pkg::ST_IDLE;
         end
      endcase
      next_link_stat.partial_down = next_pd_level == sar_port_pkg::PD_PARTIAL;
      next_link_stat.full_down = next_pd_level == sar_port_pkg::PD_FULL;
      next_link_stat.recovering = next_recover != 5'h00;
      next_link_stat.cal_pending = next_cal;
   end

   always_ff @(posedge shift_clk or posedge rst) begin
      if (rst) begin
         state <= sar_port_pkg::ST_IDLE;
         pd_level <= sar_port_pkg::PD_NONE;
         link_stat <= '{partial_down: 1'b0, full_down: 1'b0,
                        recovering: 1'b0, cal_pending: 1'b1};
         strobe_q <= 1'b1;
         edge_cnt <= 5'h00;
         low_cnt <= 4'h0;
         recover <= 5'h00;
         cal <= 1'b1;
         wake_tgl <= 1'b0;
         data_out <= 1'b0;
         data_out_oe <= 1'b0;
         track_mode <= 1'b1;
         dac_trial <= 12'h000;
      end else begin
         state <= next_state;
         pd_level <= next_pd_level;
         link_stat <= next_link_stat;
         strobe_q <= next_strobe_q;
         edge_cnt <= next_edge_cnt;
         low_cnt <= next_low_cnt;
         recover <= next_recover;
         cal <= next_cal;
         wake_tgl <= next_wake_tgl;
         data_out <= next_data_out;
         data_out_oe <= next_data_out_oe;
         track_mode <= next_track_mode;
         dac_trial <= next_dac_trial;
      end
   end

   // ----------------------------------------------------------------------
   // Link domain checks
   // ----------------------------------------------------------------------
   track_hold_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_IDLE && strobe_q && !convert_start_strobe)
      |=> !track_mode && state == sar_port_pkg::ST_CONVERT)
      else $error("track/hold not in hold after strobe fall");

   drive_low_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_IDLE && strobe_q && !convert_start_strobe)
      |=> data_out_oe && !data_out)
      else $error("data output not driven low at conversion start");

   leading_zeros_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_IDLE && strobe_q && !convert_start_strobe)
      |=> !data_out [*3])
      else $error("leading zero missing");

   msb_edge_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_CONVERT && edge_cnt == 5'h03 &&
       !convert_start_strobe)
      |=> data_out == ($past(cmp_above) ^ BIPOLAR))
      else $error("MSB not shown at 4th edge");

   bit_direct_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_CONVERT && edge_cnt >= 5'h04 &&
       edge_cnt <= 5'h0E && !convert_start_strobe)
      |=> data_out == $past(cmp_above))
      else $error("resolved bit not presented at once");

   track_return_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_CONVERT && edge_cnt == 5'h0C &&
       !convert_start_strobe)
      |=> !track_mode ##1 track_mode)
      else $error("tracking not resumed at 14th edge");

   release_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_CONVERT && edge_cnt == 5'h10 &&
       !convert_start_strobe)
      |=> !data_out_oe)
      else $error("data output not released after frame");

   keep_drive_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_CONVERT && edge_cnt == 5'h0F &&
       convert_start_strobe)
      |=> data_out_oe && !data_out && state == sar_port_pkg::ST_IDLE)
      else $error("output dropped in continuous mode");

   pd_entry_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_CONVERT && convert_start_strobe &&
       edge_cnt >= 5'h03 && edge_cnt <= 5'h0D)
      |=> state == sar_port_pkg::ST_POWER_DOWN && !data_out_oe &&
          pd_level == sar_port_pkg::PD_PARTIAL)
      else $error("partial power-down not entered");

   full_entry_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_POWER_DOWN && strobe_rise &&
       pd_level == sar_port_pkg::PD_PARTIAL && low_cnt >= 4'h3 &&
       low_cnt <= 4'hD)
      |=> pd_level == sar_port_pkg::PD_FULL)
      else $error("full power-down not entered");

   wake_a: assert property (@(posedge shift_clk) disable iff (rst)
      (state == sar_port_pkg::ST_POWER_DOWN && strobe_rise &&
       low_cnt >= 4'hE)
      |=> pd_level == sar_port_pkg::PD_NONE &&
          state == sar_port_pkg::ST_IDLE)
      else $error("power-down not left after 14 low edges");

   // ----------------------------------------------------------------------
   // Crossing into ref_clk
   // ----------------------------------------------------------------------
   // Status bits are independent levels; a one-cycle skew between them
   // is harmless. The wake request is a toggle, so no event is lost.
   logic wake_tgl_sync;

   sync_level #(
      .WIDTH(5)
   ) u_status_sync (
      .clk(ref_clk),
      .rst(rst),
      .d({link_stat, wake_tgl}),
      .q({status, wake_tgl_sync})
   );

   // ----------------------------------------------------------------------
   // Full power-down recovery timer
   // ----------------------------------------------------------------------
   logic wake_seen, next_wake_seen;
   logic [WAKE_W-1:0] wake_cnt, next_wake_cnt;
   logic next_wake_busy;

   always_comb begin
      next_wake_seen = wake_tgl_sync;
      next_wake_cnt = wake_cnt;
      if (wake_tgl_sync != wake_seen) begin
         next_wake_cnt = WAKE_LOAD;
      end else if (wake_cnt != '0) begin
         next_wake_cnt = WAKE_W'(wake_cnt - 1'b1);
      end
      next_wake_busy = next_wake_cnt != '0;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_seen <= 1'b0;
         wake_cnt <= '0;
         wake_busy <= 1'b0;
      end else begin
         wake_seen <= next_wake_seen;
         wake_cnt <= next_wake_cnt;
         wake_busy <= next_wake_busy;
      end
   end

   wake_time_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(wake_busy) |-> wake_cnt == WAKE_LOAD)
      else $error("full wake timer not loaded with its time");

endmodule // sar_conversion_port

`default_nettype wire

// File: testbench/sar_master.sv
// Serial master model: drives strobe and shift clock, samples the line.
// Assumes the bench calls one task at a time; clock stands still between.
`timescale 1ns/1ps
`default_nettype none

module sar_master (
   // Link to the port
   output var logic shift_clk,
   output var logic convert_start_strobe,
   input wire logic data_out,
   input wire logic data_out_oe
);
   logic last_bit;

   initial begin
      shift_clk = 1'b0;
      convert_start_strobe = 1'b1;
      last_bit = 1'b0;
   end

   // -------------------------------------------------------------------
   // Idle rises with the strobe high
   // -------------------------------------------------------------------
   task automatic idle(input int n);
      convert_start_strobe = 1'b1;
      repeat (n) begin
         #3 shift_clk = 1'b1;
         #3 shift_clk = 1'b0;
      end
   endtask

   // -------------------------------------------------------------------
   // n rises after the strobe falls; strobe raised at the fall after rise up
   // -------------------------------------------------------------------
   // Edge i lands at bit 17-i; a released line reads as the inverse
   // of the last bit so a stale value never passes.
   task automatic frame(input int n, input int up, output logic [16:0] bits,
         output logic [16:0] oes, output logic [16:0] moved);
      logic s;
      bits = '0;
      oes = '0;
      moved = '0;
      convert_start_strobe = 1'b0;
      #3;
      for (int i = 1; i <= n; i++) begin
         shift_clk = 1'b1;
         #1 s = data_out_oe ? data_out : ~last_bit;
         last_bit = s;
         bits[17-i] = s;
         oes[17-i] = data_out_oe;
         #2 shift_clk = 1'b0;
         if (i == up) convert_start_strobe = 1'b1;
         #2 moved[17-i] = data_out_oe && (data_out !== s);
         #1;
      end
   endtask
endmodule // sar_master

`default_nettype wire

// File: testbench/test_sar_conversion_port.sv
// Self-checking bench of the serial conversion port.
// Assumes the master model drives the link; a comparator model answers.
`timescale 1ns/1ps
`default_nettype none

module test_sar_conversion_port;
   logic ref_clk = 1'b0;
   logic rst = 1'b0;
   logic cmp_above;
   logic shift_clk;
   logic convert_start_strobe;
   logic data_out;
   logic data_out_oe;
   logic [11:0] dac_trial;
   logic track_mode;
   sar_port_pkg::link_status_s status;
   logic wake_busy;
   logic bip_out;
   logic [11:0] target = 12'h96d;
   logic [16:0] bits, oes, moved, trk, bip;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;

   always #25 ref_clk = ~ref_clk;

   // Ideal comparator: keep the trial bit while the input reaches it
   assign cmp_above = (target >= dac_trial);

   // Short wake count keeps the run brief
   sar_conversion_port #(.FULL_WAKE_CYCLES(20)) dut_u (
      .ref_clk(ref_clk),
      .rst(rst),
      .shift_clk(shift_clk),
      .convert_start_strobe(convert_start_strobe),
      .data_out(data_out),
      .data_out_oe(data_out_oe),
      .cmp_above(cmp_above),
      .dac_trial(dac_trial),
      .track_mode(track_mode),
      .status(status),
      .wake_busy(wake_busy)
   );

   // Bipolar twin on the same link and comparator; only its line is read
   sar_conversion_port #(.BIPOLAR(1'b1), .FULL_WAKE_CYCLES(20)) dut_b (
      .ref_clk(ref_clk),
      .rst(rst),
      .shift_clk(shift_clk),
      .convert_start_strobe(convert_start_strobe),
      .data_out(bip_out),
      .data_out_oe(),
      .cmp_above(cmp_above),
      .dac_trial(),
      .track_mode(),
      .status(),
      .wake_busy()
   );

   sar_master m_u (
      .shift_clk(shift_clk),
      .convert_start_strobe(convert_start_strobe),
      .data_out(data_out),
      .data_out_oe(data_out_oe)
   );

   // Track/hold and bipolar line seen just after each rise
   always @(posedge shift_clk) begin
      #1 trk = {trk[15:0], track_mode};
      bip = {bip[15:0], bip_out};
   end

   // -------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------
   task automatic chk(input string name, input logic [16:0] exp,
         input logic [16:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wait_ref(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   function automatic logic [16:0] frame_of(input logic [11:0] t);
      return {1'b0, 3'b000, t, 1'b0};
   endfunction

   task automatic tally_and_finish();
      if (mismatches == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_reset();
      chk("oe_rst", 17'h0, {16'h0, data_out_oe});
      chk("track_rst", 17'h1, {16'h0, track_mode});
      @(negedge ref_clk) rst = 1'b0;
      wait_ref(5);
      chk("track_up", 17'h1, {16'h0, track_mode});
      chk("cal_flag", 17'h1, {13'h0, status});
   endtask

   task automatic t_single();
      m_u.idle(2);
      trk = '0;
      // Calibration frame: checked here, never used as a result
      m_u.frame(17, 0, bits, oes, moved);
      chk("frame", frame_of(target), {1'b0, bits[16:1]});
      chk("bipolar", frame_of(target ^ 12'h800),
         {1'b0, bip[16:1]});
      chk("oe", 17'h1_fffe, oes);
      chk("moved", 17'h0, moved);
      chk("track", 17'h0_000f, trk);
      wait_ref(5);
      chk("cal_done", 17'h0, {13'h0, status});
   endtask

   task automatic t_back_to_back();
      m_u.idle(2);
      target = 12'hfff;
      m_u.frame(16, 14, bits, oes, moved);
      chk("b2b_a", frame_of(target), {1'b0, bits[16:1]});
      chk("b2b_a_oe", 17'h1_fffe, oes);
      target = 12'h000;
      m_u.frame(17, 0, bits, oes, moved);
      chk("b2b_b", frame_of(target), {1'b0, bits[16:1]});
      chk("b2b_b_oe", 17'h1_fffe, oes);
   endtask

   task automatic t_abort();
      m_u.idle(2);
      m_u.frame(2, 1, bits, oes, moved);
      chk("abort_oe", 17'h1_0000, oes);
      wait_ref(5);
      chk("abort_st", 17'h0, {13'h0, status});
      chk("abort_trk", 17'h1, {16'h0, track_mode});
   endtask

   task automatic t_power_down();
      m_u.idle(2);
      m_u.frame(4, 3, bits, oes, moved);
      chk("pd_oe", 17'h1_c000, oes);
      wait_ref(5);
      chk("partial", 17'h8, {13'h0, status});
      m_u.frame(4, 3, bits, oes, moved);
      chk("full_oe", 17'h0, oes);
      wait_ref(5);
      chk("full", 17'h4, {13'h0, status});
      m_u.frame(15, 14, bits, oes, moved);
      chk("wake_oe", 17'h0, oes);
      wait_ref(6);
      chk("busy", 17'h1, {16'h0, wake_busy});
      wait_ref(40);
      chk("busy_end", 17'h0, {16'h0, wake_busy});
      chk("awake", 17'h0, {13'h0, status});
      m_u.frame(4, 3, bits, oes, moved);
      m_u.frame(15, 14, bits, oes, moved);
      // Clock stands still here, so the recovery count holds
      wait_ref(5);
      chk("recovering", 17'h2, {13'h0, status});
      m_u.idle(17);
      wait_ref(5);
      chk("recovered", 17'h0, {13'h0, status});
      target = 12'h5a6;
      m_u.idle(1);
      m_u.frame(17, 0, bits, oes, moved);
      chk("after_wake", frame_of(target), {1'b0, bits[16:1]});
   endtask

   initial begin
      // Rise after time zero so the asynchronous reset edge is seen
      #1 rst = 1'b1;
      wait_ref(5);
      t_reset();
      t_single();
      t_back_to_back();
      t_abort();
      t_power_down();
      tally_and_finish();
   end
endmodule // test_sar_conversion_port

`default_nettype wire
